// File: hw/gooseq_map.svh
// Offsets, fields, reset values and timing counts of the group sequencer.
// Included by the package, the sequencer and the bench; holds definitions only.
`ifndef GOOSEQ_MAP_SVH
`define GOOSEQ_MAP_SVH

`define GOOSEQ_CLK_HZ        200000000
`define GOOSEQ_TICK_MS       10
`define GOOSEQ_TICK_CYC      ((`GOOSEQ_CLK_HZ / 1000) * `GOOSEQ_TICK_MS)
`define GOOSEQ_DLY_MIN_MS    10
`define GOOSEQ_DLY_MAX_MS    20000
`define GOOSEQ_DLY_MIN_TK    (`GOOSEQ_DLY_MIN_MS / `GOOSEQ_TICK_MS)
`define GOOSEQ_DLY_MAX_TK    (`GOOSEQ_DLY_MAX_MS / `GOOSEQ_TICK_MS)
`define GOOSEQ_FLASH_MS      250
`define GOOSEQ_FLASH_TK      (`GOOSEQ_FLASH_MS / `GOOSEQ_TICK_MS)
`define GOOSEQ_BLINK_TK      25

// Register byte offsets
`define GOOSEQ_ACT_OFS       12'h000
`define GOOSEQ_ON_DLY_OFS    12'h010
`define GOOSEQ_OFF_DLY_OFS   12'h020
`define GOOSEQ_CMD_OFS       12'h030
`define GOOSEQ_STAT_OFS      12'h034

// Action register: out i on action at [2i+1:2i], off action at [9+2i:8+2i]
`define GOOSEQ_ACT_OFF_LSB   8
// Command register bits (write one to act)
`define GOOSEQ_CMD_ON        0
`define GOOSEQ_CMD_OFF       1
`define GOOSEQ_CMD_FACT      2
`define GOOSEQ_CMD_OUT_LSB   4
`define GOOSEQ_CMD_RCL       8
`define GOOSEQ_CMD_RST_LSB   12
// Status bits
`define GOOSEQ_ST_OUT_LSB    0
`define GOOSEQ_ST_NDEF       4
`define GOOSEQ_ST_PNDEF_LSB  8
`define GOOSEQ_ST_BUSY_ON    12
`define GOOSEQ_ST_BUSY_OFF   13
`define GOOSEQ_ST_LAMP_ON    14
`define GOOSEQ_ST_LAMP_OFF   15

`define GOOSEQ_ACT_RST       2'h0
`define GOOSEQ_DLY_RST       11'h001
`define GOOSEQ_RESP_OKAY     2'h0
`define GOOSEQ_RESP_SLVERR   2'h2

`endif

// File: hw/gooseq_pkg.sv
// Types shared by the group output sequencer.
// Assumes gooseq_map.svh is reachable on the include path.
`include "gooseq_map.svh"
package gooseq_pkg;
  typedef enum logic [1:0] {
    GOOSEQ_IMMED = 2'b00,
    GOOSEQ_DELAY = 2'b01,
    GOOSEQ_EXCL  = 2'b10
  } gooseq_act_t;

  typedef enum logic [1:0] {
    GOOSEQ_IDLE   = 2'b00,
    GOOSEQ_RUN_ON = 2'b01,
    GOOSEQ_RUN_OF = 2'b10
  } gooseq_st_t;

  typedef struct packed {
    gooseq_st_t       seq;
    logic [3:0]       pend;
    logic [10:0]      tmr;
    logic [20:0]      pre;
    logic [4:0]       blink;
    logic [3:0]       out_en;
    logic [1:0]       lamp;
    logic             lamp_on;
    logic             lamp_off;
    logic [1:0]       key_q;
    logic [15:0]      act;
    logic [3:0][10:0] dly_on;
    logic [3:0][10:0] dly_off;
    logic [3:0]       ndef;
    logic             ndef_any;
    logic             aw_ok;
    logic             awready;
    logic             w_ok;
    logic             wready;
    logic [11:0]     awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } gooseq_state_t;
endpackage : gooseq_pkg

// File: hw/gooseq_top.sv
// Group-on / group-off output sequencer with AXI4-Lite settings registers.
// Assumes keys are clean one-cycle-or-level inputs synchronous to aclk.
// What this block does
// - With default actions the group keys switch all four outputs together.
// - Every output has an on and an off action: immediate, delay or exclude.
// - Factory reset makes every action immediate; immediate acts on the key.
// - A delayed action waits 10 ms to 20000 ms from key press to command.
// - An excluded output keeps its state when its group key is pressed, save a group-off again or held in an off sequence.
// - Leaving delayed keeps the stored delay for when delayed returns.
// - Flags show any non-immediate action, globally and per output.
// - The delay times only the switch command; slew adds no counted time.
// - The key lamp flashes until a long sequence ends, dark below 250 ms.
// - Group-off again or held in an off sequence turns every output off.
// - An output's own key toggles it at once and cancels its pending action.
// - Factory default clears every action and leaves stored memories.
// - Delays count in 10 ms ticks.
// - Recalled memory states apply with no delay.
`timescale 1ns/1ps
`default_nettype none
`include "gooseq_map.svh"
module gooseq_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        key_grp_on,
  input  wire logic        key_grp_off,
  input  wire logic [3:0]  key_out,
  input  wire logic        recall_stb,
  input  wire logic [3:0]  recall_state,
  output logic [3:0]       out_en,
  output logic             lamp_grp_on,
  output logic             lamp_grp_off,
  output logic             non_default,
  output logic [3:0]       out_non_default,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import gooseq_pkg::*;

  gooseq_state_t s_r;
  gooseq_state_t s_nxt;

  // Clamp a written delay into the legal tick range
  function automatic logic [10:0] clamp_dly(input logic [15:0] v);
    if (v < 16'(`GOOSEQ_DLY_MIN_TK))
      return 11'(`GOOSEQ_DLY_MIN_TK);
    else if (v > 16'(`GOOSEQ_DLY_MAX_TK))
      return 11'(`GOOSEQ_DLY_MAX_TK);
    else
      return v[10:0];
  endfunction : clamp_dly

  // Action field of output i, on or off side
  function automatic logic [1:0] act_of(input logic [15:0] a,
                                        input int i, input logic off);
    return off ? a[`GOOSEQ_ACT_OFF_LSB + 2*i +: 2] : a[2*i +: 2];
  endfunction : act_of

  function automatic logic [31:0] pack_dly(input logic [3:0][10:0] d,
                                           input int i);
    return {21'h0, d[i]};
  endfunction : pack_dly

  logic [3:0]  ndef;
  logic [3:0]  wr_cmd_out;
  logic [31:0] cmd_bits;
  logic [10:0] maxd;
  logic        wr_go;
  logic        grp_on_ev;
  logic        grp_off_ev;
  logic        fact_ev;
  logic        tick;

  always_comb begin
    s_nxt = s_r;
    ndef = 4'h0;
    maxd = 11'h0;
    cmd_bits = 32'h0;
    // Non-default flags per output
    for (int i = 0; i < 4; i++) begin
      ndef[i] = (act_of(s_r.act, i, 1'b0) != GOOSEQ_IMMED) ||
                (act_of(s_r.act, i, 1'b1) != GOOSEQ_IMMED);
    end
    s_nxt.ndef = ndef;
    s_nxt.ndef_any = |ndef;

    // AXI write: address and data in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    wr_go = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
    if (wr_go) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `GOOSEQ_RESP_OKAY;
      unique case (s_r.awaddr)
        `GOOSEQ_ACT_OFS: begin
          if (s_r.wstrb[0])
            s_nxt.act[7:0] = s_r.wdata[7:0];
          if (s_r.wstrb[1])
            s_nxt.act[15:8] = s_r.wdata[15:8];
        end
        `GOOSEQ_CMD_OFS: begin
          cmd_bits = s_r.wdata;
        end
        default: begin
          if (s_r.awaddr >= `GOOSEQ_ON_DLY_OFS &&
              s_r.awaddr < `GOOSEQ_CMD_OFS && s_r.awaddr[1:0] == 2'h0) begin
            if (s_r.awaddr[5])
              s_nxt.dly_off[s_r.awaddr[3:2]] =
                clamp_dly(s_r.wdata[15:0]);
            else
              s_nxt.dly_on[s_r.awaddr[3:2]] =
                clamp_dly(s_r.wdata[15:0]);
          end else begin
            s_nxt.bresp = `GOOSEQ_RESP_SLVERR;
          end
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    // Ready flags mirror an empty slot, kept as registers
    s_nxt.awready = !s_nxt.aw_ok;
    s_nxt.wready = !s_nxt.w_ok;

    // AXI read: one outstanding, data a cycle after the address
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `GOOSEQ_RESP_OKAY;
      s_nxt.rdata = 32'h0;
      unique case (s_axi_araddr)
        `GOOSEQ_ACT_OFS:  s_nxt.rdata = {16'h0, s_r.act};
        `GOOSEQ_CMD_OFS:  s_nxt.rdata = 32'h0;
        `GOOSEQ_STAT_OFS: s_nxt.rdata = {16'h0, s_r.lamp, s_r.seq, ndef,
                                         3'h0, |ndef, s_r.out_en};
        default: begin
          if (s_axi_araddr >= `GOOSEQ_ON_DLY_OFS &&
              s_axi_araddr < `GOOSEQ_CMD_OFS && s_axi_araddr[1:0] == 2'h0)
            s_nxt.rdata = s_axi_araddr[5] ?
                          pack_dly(s_r.dly_off, int'(s_axi_araddr[3:2])) :
                          pack_dly(s_r.dly_on, int'(s_axi_araddr[3:2]));
          else
            s_nxt.rresp = `GOOSEQ_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Key edges, from pins or command register
    s_nxt.key_q = {key_grp_off, key_grp_on};
    grp_on_ev = (key_grp_on && !s_r.key_q[0]) || cmd_bits[`GOOSEQ_CMD_ON];
    grp_off_ev = (key_grp_off && !s_r.key_q[1]) ||
                 cmd_bits[`GOOSEQ_CMD_OFF];
    fact_ev = cmd_bits[`GOOSEQ_CMD_FACT];
    wr_cmd_out = cmd_bits[`GOOSEQ_CMD_OUT_LSB +: 4];

    // 10 ms timebase, restarted with each sequence
    tick = (s_r.pre == 21'(`GOOSEQ_TICK_CYC - 1));
    s_nxt.pre = tick ? 21'h0 : s_r.pre + 21'h1;
    s_nxt.blink = (tick && s_r.blink != 5'h0) ? s_r.blink - 5'h1 : s_r.blink;
    if (tick && s_r.blink == 5'h0)
      s_nxt.blink = 5'(`GOOSEQ_BLINK_TK - 1);

    unique case (s_r.seq)
      GOOSEQ_IDLE: begin
      end
      GOOSEQ_RUN_ON, GOOSEQ_RUN_OF: begin
        if (tick) begin
          s_nxt.tmr = s_r.tmr + 11'h1;
          for (int i = 0; i < 4; i++) begin
            if (s_r.pend[i] && s_nxt.tmr >= (s_r.seq == GOOSEQ_RUN_ON ?
                s_r.dly_on[i] : s_r.dly_off[i])) begin
              s_nxt.pend[i] = 1'b0;
              s_nxt.out_en[i] = (s_r.seq == GOOSEQ_RUN_ON);
            end
          end
        end
        if (s_nxt.pend == 4'h0)
          s_nxt.seq = GOOSEQ_IDLE;
      end
      default: s_nxt.seq = GOOSEQ_IDLE;
    endcase

    // Group key starts a fresh sequence; group-off in an off sequence ends it
    if (grp_off_ev && s_r.seq == GOOSEQ_RUN_OF) begin
      s_nxt.out_en = 4'h0;
      s_nxt.pend = 4'h0;
      s_nxt.seq = GOOSEQ_IDLE;
    end else if (grp_on_ev || grp_off_ev) begin
      s_nxt.pend = 4'h0;
      s_nxt.tmr = 11'h0;
      s_nxt.pre = 21'h0;
      s_nxt.blink = 5'h0;
      for (int i = 0; i < 4; i++) begin
        unique case (gooseq_act_t'(act_of(s_r.act, i, grp_off_ev)))
          GOOSEQ_IMMED: s_nxt.out_en[i] = grp_on_ev && !grp_off_ev;
          GOOSEQ_DELAY: begin
            s_nxt.pend[i] = 1'b1;
            if ((grp_off_ev ? s_r.dly_off[i] : s_r.dly_on[i]) > maxd)
              maxd = grp_off_ev ? s_r.dly_off[i] : s_r.dly_on[i];
          end
          GOOSEQ_EXCL: begin
          end
          default: begin
          end
        endcase
      end
      s_nxt.seq = (s_nxt.pend == 4'h0) ? GOOSEQ_IDLE :
                  (grp_off_ev ? GOOSEQ_RUN_OF : GOOSEQ_RUN_ON);
      s_nxt.lamp = 2'h0;
      if (maxd >= 11'(`GOOSEQ_FLASH_TK))
        s_nxt.lamp = grp_off_ev ? 2'h2 : 2'h1;
    end else if (s_r.seq == GOOSEQ_RUN_OF && key_grp_off && s_r.key_q[1] &&
                 tick && s_r.tmr >= 11'(`GOOSEQ_FLASH_TK)) begin
      s_nxt.out_en = 4'h0;
      s_nxt.pend = 4'h0;
      s_nxt.seq = GOOSEQ_IDLE;
    end

    if (s_nxt.seq == GOOSEQ_IDLE)
      s_nxt.lamp = 2'h0;

    // Own keys override a pending action
    for (int i = 0; i < 4; i++) begin
      if (key_out[i] || wr_cmd_out[i]) begin
        s_nxt.out_en[i] = !s_r.out_en[i];
        s_nxt.pend[i] = 1'b0;
      end
    end
    if (recall_stb || cmd_bits[`GOOSEQ_CMD_RCL]) begin
      s_nxt.out_en = recall_stb ? recall_state :
                     cmd_bits[`GOOSEQ_CMD_RST_LSB +: 4];
      s_nxt.pend = 4'h0;
      s_nxt.seq = GOOSEQ_IDLE;
      s_nxt.lamp = 2'h0;
    end
    if (fact_ev)
      s_nxt.act = {8{`GOOSEQ_ACT_RST}};
    // Lamp pins blink on half the blink period, from registers
    s_nxt.lamp_on = s_nxt.lamp[0] &&
                    (s_nxt.blink < 5'(`GOOSEQ_BLINK_TK / 2));
    s_nxt.lamp_off = s_nxt.lamp[1] &&
                     (s_nxt.blink < 5'(`GOOSEQ_BLINK_TK / 2));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        s_r.dly_on[i] <= `GOOSEQ_DLY_RST;
        s_r.dly_off[i] <= `GOOSEQ_DLY_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_en          = s_r.out_en;
  assign lamp_grp_on     = s_r.lamp_on;
  assign lamp_grp_off    = s_r.lamp_off;
  assign non_default     = s_r.ndef_any;
  assign out_non_default = s_r.ndef;
  assign s_axi_awready   = s_r.awready;
  assign s_axi_wready    = s_r.wready;
  assign s_axi_bvalid    = s_r.bvalid;
  assign s_axi_bresp     = s_r.bresp;
  assign s_axi_arready   = s_r.arready;
  assign s_axi_rvalid    = s_r.rvalid;
  assign s_axi_rdata     = s_r.rdata;
  assign s_axi_rresp     = s_r.rresp;
endmodule : gooseq_top
`default_nettype wire

// File: test/gooseq_sva.sv
// Port checker for the group output sequencer.
// Bound to gooseq_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module gooseq_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       key_grp_on,
  input wire logic       key_grp_off,
  input wire logic [3:0] key_out,
  input wire logic       recall_stb,
  input wire logic [3:0] recall_state,
  input wire logic [3:0] out_en,
  input wire logic       non_default,
  input wire logic [3:0] out_non_default,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic quiet;
  assign quiet = !recall_stb && key_out == 4'h0;
  a_grp_on_all: assert property (
    !non_default && quiet && !key_grp_off && $rose(key_grp_on)
    |-> ##[1:3] out_en == 4'hF) else $error("group on missed outputs");
  a_grp_off_all: assert property (
    !non_default && quiet && !key_grp_on && $rose(key_grp_off)
    |-> ##[1:3] out_en == 4'h0) else $error("group off missed outputs");
  a_ndef_any: assert property (
    non_default == (out_non_default != 4'h0))
    else $error("global and per-output flags disagree");
  a_recall_now: assert property (
    recall_stb |=> out_en == $past(recall_state))
    else $error("recalled state not applied at once");
  a_own_toggle: assert property (
    key_out != 4'h0 && !recall_stb && !$rose(key_grp_on)
    && !$rose(key_grp_off)
    |=> ((out_en ^ $past(out_en)) & $past(key_out)) == $past(key_out))
    else $error("own key did not act at once");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_b_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule : gooseq_sva
`default_nettype wire

// File: test/gooseq_load.sv
// Load model for the four output enables: counts switching events.
// Assumes out_en is registered on aclk.
`timescale 1ns/1ps
`default_nettype none
module gooseq_load (
  input  wire logic       aclk,
  input  wire logic [3:0] out_en,
  output logic [7:0]      switch_events
);
  logic [3:0] seen_r = 4'h0;
  logic [7:0] count_r = 8'h00;
  assign switch_events = count_r;
  // One event per cycle in which any enable moved
  always @(posedge aclk) begin
    seen_r <= out_en;
    if (out_en !== seen_r)
      count_r <= count_r + 8'h01;
  end
endmodule : gooseq_load
`default_nettype wire

// File: test/gooseq_top_test.sv
// Bench for the group sequencer: bus, keys, recall and verdict.
// Assumes a 10 ms tick far longer than the whole run.
`timescale 1ns/1ps
`default_nettype none
`include "gooseq_map.svh"
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module gooseq_top_test;
  localparam logic [11:0] ACT  = `GOOSEQ_ACT_OFS;
  localparam logic [11:0] OND  = `GOOSEQ_ON_DLY_OFS;
  localparam logic [11:0] CMD  = `GOOSEQ_CMD_OFS;
  localparam logic [11:0] STAT = `GOOSEQ_STAT_OFS;
  logic        aclk, aresetn, key_grp_on, key_grp_off, recall_stb;
  logic [3:0]  key_out, recall_state, out_en, out_non_default, s_axi_wstrb;
  logic        lamp_grp_on, lamp_grp_off, non_default;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  switch_events;
  int          fail_count, comparisons;
  gooseq_top gooseq_top_inst (.*);
  gooseq_load gooseq_load_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic hang;
    fail_count++;
    give_verdict();
  endtask : hang
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
      if (s_axi_bvalid) break;
      if (++n > 40) hang();
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      if (s_axi_rvalid) break;
      if (++n > 40) hang();
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK(r, 2'h0)
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `CHK(r, 2'h0)
    `CHK(d, e)
  endtask : rd_chk
  task automatic press(input logic off);
    @(posedge aclk);
    key_grp_on  <= !off;
    key_grp_off <= off;
    repeat (2) @(posedge aclk);
    key_grp_on  <= 1'b0;
    key_grp_off <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
  endtask : press
  task automatic own(input logic [3:0] m);
    @(posedge aclk);
    key_out <= m;
    @(posedge aclk);
    key_out <= 4'h0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : own
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(ACT, 32'h0);
    rd_chk(OND, 32'h1);
    `CHK(non_default, 1'b0)
    axi_rd(12'h040, d, r);
    `CHK({r, d}, 34'h2_0000_0000)
    axi_wr(12'h040, 32'h1, r);
    `CHK(r, 2'h2)
  endtask : t_reset
  task automatic t_group;
    logic [7:0] e;
    e = switch_events;
    press(1'b0);
    `CHK(out_en, 4'hF)
    `CHK(switch_events, e + 8'h01)
    press(1'b1);
    `CHK(out_en, 4'h0)
  endtask : t_group
  task automatic t_exclude;
    wr(ACT, 32'h802);
    rd_chk(ACT, 32'h802);
    `CHK({non_default, out_non_default}, 5'h13)
    press(1'b0);
    `CHK(out_en, 4'hE)
    own(4'h1);
    `CHK(out_en, 4'hF)
    press(1'b1);
    `CHK(out_en, 4'h2)
  endtask : t_exclude
  task automatic t_emerg;
    wr(ACT, 32'h5800);
    press(1'b0);
    `CHK(out_en, 4'hF)
    press(1'b1);
    `CHK(out_en, 4'hE)
    own(4'h4);
    `CHK(out_en, 4'hA)
    press(1'b1);
    `CHK(out_en, 4'h0)
  endtask : t_emerg
  task automatic t_retain;
    wr(OND + 12'h00C, 32'h7D0);
    rd_chk(OND + 12'h00C, 32'h7D0);
    wr(OND + 12'h008, 32'h0);
    rd_chk(OND + 12'h008, 32'h1);
    wr(ACT, 32'h40);
    rd_chk(ACT, 32'h40);
    `CHK(out_non_default, 4'h8)
    wr(ACT, 32'h80);
    rd_chk(OND + 12'h00C, 32'h7D0);
    wr(CMD, 32'h4);
    rd_chk(ACT, 32'h0);
    `CHK(non_default, 1'b0)
    rd_chk(OND + 12'h00C, 32'h7D0);
  endtask : t_retain
  task automatic t_recall;
    @(posedge aclk);
    recall_state <= 4'h5;
    recall_stb   <= 1'b1;
    @(posedge aclk);
    recall_stb <= 1'b0;
    @(posedge aclk);
    #1;
    `CHK(out_en, 4'h5)
    rd_chk(STAT, 32'h5);
  endtask : t_recall
  task automatic t_lamp;
    wr(CMD, 32'h100);
    `CHK(out_en, 4'h0)
    wr(OND, 32'h7D0);
    wr(ACT, 32'h1);
    press(1'b0);
    `CHK(out_en, 4'hE)
    `CHK({lamp_grp_on, lamp_grp_off}, 2'h2)
    rd_chk(STAT, 32'h511E);
    wr(CMD, 32'h10);
    #1;
    `CHK(out_en, 4'hF)
    `CHK(lamp_grp_on, 1'b0)
    wr(CMD, 32'h2);
    #1;
    `CHK(out_en, 4'h0)
  endtask : t_lamp
  initial begin
    {key_grp_on, key_grp_off, recall_stb, key_out, recall_state} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_group();
    t_exclude();
    t_emerg();
    t_retain();
    t_recall();
    t_lamp();
    give_verdict();
  end
endmodule : gooseq_top_test
bind gooseq_top gooseq_sva gooseq_sva_inst (.*);
`default_nettype wire
